// ### rtl/pma_defines.svh
// register offsets, field positions and timing constants for the phy management block
`ifndef PMA_DEFINES_SVH
`define PMA_DEFINES_SVH
`define PMA_IDX_HASH_LOW    8'h05
`define PMA_IDX_HASH_HIGH   8'h04
`define PMA_IDX_CONTROL     8'h06
`define PMA_IDX_VALUE       8'h07
`define PMA_IDX_MAC_CTRL    8'h09
`define PMA_ADDR_HASH_LOW   12'h014
`define PMA_ADDR_HASH_HIGH  12'h010
`define PMA_ADDR_CONTROL    12'h018
`define PMA_ADDR_VALUE      12'h01c
`define PMA_ADDR_MAC_CTRL   12'h024
`define PMA_PHY_HI          15
`define PMA_PHY_LO          11
`define PMA_REG_HI          10
`define PMA_REG_LO          6
`define PMA_WNR_BIT         1
`define PMA_BUSY_BIT        0
`define PMA_ACCEPT_ALL_BIT  19
`define PMA_HASH_RESET      32'h0000_0000
`define PMA_VALUE_RESET     16'h0000
`define PMA_FIELD5_RESET    5'h00
`define PMA_HASH_SEL_BIT    5
`define PMA_PHY_LAT_NS      1000
`define PMA_CLK_NS          100
`define PMA_PHY_LAT_CYC     ((`PMA_PHY_LAT_NS + `PMA_CLK_NS - 1) / `PMA_CLK_NS)
`endif

// ### rtl/pma_pkg.sv
// types for the phy management access block
package pma_pkg;
   typedef enum logic [1:0] {
      PMA_IDLE   = 2'b00,
      PMA_LAUNCH = 2'b01,
      PMA_WAIT   = 2'b11,
      PMA_DONE   = 2'b10
   } pma_state_t;
endpackage

// ### rtl/pma_phy_regs.sv
// internal phy management register file: 32 phys by 32 registers of 16 bits, fixed latency
`timescale 1ns/10ps
`include "pma_defines.svh"
module pma_phy_regs (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        reqValid,
   input  wire logic        reqWrite,
   input  wire logic [4:0]  reqPhy,
   input  wire logic [4:0]  reqReg,
   input  wire logic [15:0] reqData,
   output logic             ackValid,
   output logic [15:0]      ackData
);
   localparam int LAT = `PMA_PHY_LAT_CYC;
   logic [15:0] store [0:1023];
   logic [7:0]  latCount;
   logic        pending;
   logic        pendWrite;
   logic [9:0]  pendIdx;
   logic [15:0] pendData;

   // latency counter and completion of one access
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pending   <= 1'b0;
         pendWrite <= 1'b0;
         pendIdx   <= 10'h000;
         pendData  <= 16'h0000;
         latCount  <= 8'h00;
         ackValid  <= 1'b0;
         ackData   <= 16'h0000;
      end else begin
         ackValid <= 1'b0;
         if (reqValid && !pending) begin
            pending   <= 1'b1;
            pendWrite <= reqWrite;
            pendIdx   <= {reqPhy, reqReg};
            pendData  <= reqData;
            latCount  <= 8'(LAT - 1);
         end else if (pending) begin
            if (latCount == 8'h00) begin
               pending  <= 1'b0;
               ackValid <= 1'b1;
               ackData  <= store[pendIdx];
            end else begin
               latCount <= latCount - 8'h01;
            end
         end
      end
   end

   // storage update on a write completion
   always_ff @(posedge ref_clk) begin
      if (pending && latCount == 8'h00 && pendWrite) begin
         store[pendIdx] <= pendData;
      end
   end
endmodule

// ### rtl/pma_top.sv
// apb register block giving software access to internal phy management registers
// Functional notes
// R1: software loads target phy number, bits 15:11
// R2: bits 10:6 choose the phy register
// R3: bit 1 set writes, clear reads
// R4: software sets bit 0 to start access
// R5: bit 0 stays one until access completes
// R6: software polls bit 0 before writing registers
// R7: software keeps value stable during write
// R8: read value valid only after busy clears
// R9: value in bits 15:0, upper bits reserved
// R10: low hash register holds table bits 31:0
// R11: hash top bit picks register, rest bit
// R12: accept-all-group passes every multicast frame
// R13: phy, index, direction captured at launch
`timescale 1ns/10ps
`include "pma_defines.svh"
module pma_top (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        hashValid,
   input  wire logic [5:0]  hashIndex,
   output logic             groupAccept,
   output logic             accessBusy
);
   logic [31:0] groupHashLow;
   logic [31:0] groupHashHigh;
   logic [31:0] hostMacControl;
   logic [4:0]  targetPhyNumber;
   logic [4:0]  phyRegSelect;
   logic        writeNotRead;
   logic [15:0] phyValue;
   logic [4:0]  latPhy;
   logic [4:0]  latReg;
   logic        latWrite;
   logic        reqValid;
   logic        ackValid;
   logic [15:0] ackData;
   logic [63:0] hashTable;
   pma_pkg::pma_state_t state;
   logic        setupPhase;
   logic        wrAccess;
   logic        rdAccess;
   logic        mapped;
   logic [31:0] wMask;
   logic [31:0] next_readData;

   assign setupPhase = psel && !penable;
   assign wrAccess   = psel && penable && pready && pwrite;
   assign rdAccess   = psel && penable && pready && !pwrite;
   assign hashTable  = {groupHashHigh, groupHashLow};

   // byte lane mask from strobes
   generate
      for (genvar b = 0; b < 4; b++) begin : gLane
         assign wMask[8*b +: 8] = {8{pstrb[b]}};
      end
   endgenerate

   // address decode
   always_comb begin
      mapped = 1'b1;
      next_readData = 32'h0000_0000;
      case (paddr)
         `PMA_ADDR_HASH_LOW:  next_readData = groupHashLow; // [R10]
         `PMA_ADDR_HASH_HIGH: next_readData = groupHashHigh;
         `PMA_ADDR_MAC_CTRL:  next_readData = hostMacControl;
         `PMA_ADDR_CONTROL: begin
            next_readData[`PMA_PHY_HI:`PMA_PHY_LO] = targetPhyNumber;
            next_readData[`PMA_REG_HI:`PMA_REG_LO] = phyRegSelect;
            next_readData[`PMA_WNR_BIT]  = writeNotRead;
            next_readData[`PMA_BUSY_BIT] = (state != pma_pkg::PMA_IDLE); // [R5]
         end
         `PMA_ADDR_VALUE: next_readData[15:0] = phyValue; // [R9]
         default: mapped = 1'b0;
      endcase
   end

   // apb handshake: no wait state, pready and read data registered from the setup phase
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setupPhase;
         pslverr <= setupPhase && !mapped;
         if (setupPhase && !pwrite) begin
            prdata <= next_readData;
         end
      end
   end

   // hash and mac control registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         groupHashLow   <= `PMA_HASH_RESET;
         groupHashHigh  <= `PMA_HASH_RESET;
         hostMacControl <= `PMA_HASH_RESET;
      end else if (wrAccess && !pslverr) begin
         if (paddr == `PMA_ADDR_HASH_LOW) begin
            groupHashLow <= (groupHashLow & ~wMask) | (pwdata & wMask); // [R10]
         end
         if (paddr == `PMA_ADDR_HASH_HIGH) begin
            groupHashHigh <= (groupHashHigh & ~wMask) | (pwdata & wMask);
         end
         if (paddr == `PMA_ADDR_MAC_CTRL) begin
            hostMacControl <= (hostMacControl & ~wMask) | (pwdata & wMask);
         end
      end
   end

   // access control fields; ignored while an access is in flight
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         targetPhyNumber <= `PMA_FIELD5_RESET;
         phyRegSelect    <= `PMA_FIELD5_RESET;
         writeNotRead    <= 1'b0;
      end else if (wrAccess && paddr == `PMA_ADDR_CONTROL && state == pma_pkg::PMA_IDLE) begin
         if (pstrb[1]) begin
            targetPhyNumber <= pwdata[`PMA_PHY_HI:`PMA_PHY_LO]; // [R1]
         end
         if (pstrb[1] && pstrb[0]) begin
            phyRegSelect <= pwdata[`PMA_REG_HI:`PMA_REG_LO]; // [R2]
         end
         if (pstrb[0]) begin
            writeNotRead <= pwdata[`PMA_WNR_BIT]; // [R3]
         end
      end
   end

   // access sequencer: launch on busy set, clear busy on completion
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state    <= pma_pkg::PMA_IDLE;
         reqValid <= 1'b0;
         latPhy   <= `PMA_FIELD5_RESET;
         latReg   <= `PMA_FIELD5_RESET;
         latWrite <= 1'b0;
      end else begin
         reqValid <= 1'b0;
         case (state)
            pma_pkg::PMA_IDLE: begin
               if (wrAccess && paddr == `PMA_ADDR_CONTROL && pstrb[0]
                   && pwdata[`PMA_BUSY_BIT]) begin // [R4]
                  latPhy   <= pstrb[1] ? pwdata[`PMA_PHY_HI:`PMA_PHY_LO] : targetPhyNumber; // [R13]
                  latReg   <= pstrb[1] ? pwdata[`PMA_REG_HI:`PMA_REG_LO] : phyRegSelect;
                  latWrite <= pwdata[`PMA_WNR_BIT];
                  state    <= pma_pkg::PMA_LAUNCH;
               end
            end
            pma_pkg::PMA_LAUNCH: begin
               reqValid <= 1'b1;
               state    <= pma_pkg::PMA_WAIT;
            end
            pma_pkg::PMA_WAIT: begin
               if (ackValid) begin
                  state <= pma_pkg::PMA_DONE;
               end
            end
            pma_pkg::PMA_DONE: state <= pma_pkg::PMA_IDLE; // [R5]
            default: state <= pma_pkg::PMA_IDLE;
         endcase
      end
   end

   // value register: software writes when idle, read result loaded on completion
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         phyValue <= `PMA_VALUE_RESET;
      end else if (state == pma_pkg::PMA_WAIT && ackValid && !latWrite) begin
         phyValue <= ackData; // [R8]
      end else if (wrAccess && paddr == `PMA_ADDR_VALUE && state == pma_pkg::PMA_IDLE) begin
         if (pstrb[0]) begin
            phyValue[7:0] <= pwdata[7:0]; // [R9]
         end
         if (pstrb[1]) begin
            phyValue[15:8] <= pwdata[15:8];
         end
      end
   end

   // busy level out and multicast filter decision
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         accessBusy  <= 1'b0;
         groupAccept <= 1'b0;
      end else begin
         accessBusy <= (state != pma_pkg::PMA_IDLE)
                       && !(state == pma_pkg::PMA_DONE);
         groupAccept <= hashValid && (hostMacControl[`PMA_ACCEPT_ALL_BIT] // [R12]
                        || hashTable[hashIndex]); // [R11]
      end
   end

   pma_phy_regs uPhy (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .reqValid (reqValid),
      .reqWrite (latWrite),
      .reqPhy   (latPhy),
      .reqReg   (latReg),
      .reqData  (phyValue),
      .ackValid (ackValid),
      .ackData  (ackData)
   );

   // busy must hold for three cycles after launch
   AST_BUSY_HELD: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
      (state == pma_pkg::PMA_LAUNCH) |=> (state != pma_pkg::PMA_IDLE) [*3])
      else $error("busy dropped during access");
   // a launch follows a busy-set write
   AST_LAUNCH: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
      (state == pma_pkg::PMA_IDLE && wrAccess && paddr == `PMA_ADDR_CONTROL
       && pstrb[0] && pwdata[`PMA_BUSY_BIT]) |=> ##1 reqValid)
      else $error("no phy request after busy set");
   // captured fields stay stable in the wait state
   AST_STABLE: assert property (@(posedge ref_clk) disable iff (!rstn) // [R13]
      (state == pma_pkg::PMA_WAIT) |-> $stable(latPhy) && $stable(latReg) && $stable(latWrite))
      else $error("captured fields changed");
   // completion within bound
   AST_DONE_BOUND: assert property (@(posedge ref_clk) disable iff (!rstn) // [R5]
      reqValid |-> ##[1:20] (state == pma_pkg::PMA_IDLE))
      else $error("access never completed");
   // read result loaded into value
   AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (!rstn) // [R8]
      (state == pma_pkg::PMA_WAIT && ackValid && !latWrite) |=> phyValue == $past(ackData))
      else $error("read data not loaded");
   // value unchanged during write access
   AST_WR_VALUE: assert property (@(posedge ref_clk) disable iff (!rstn) // [R3]
      (state == pma_pkg::PMA_WAIT && latWrite) |=> $stable(phyValue))
      else $error("write value changed");
   // filter accepts on table bit or accept-all
   AST_FILTER: assert property (@(posedge ref_clk) disable iff (!rstn) // [R11]
      hashValid && hashTable[hashIndex] |=> groupAccept)
      else $error("hash hit rejected");
   AST_ALLGROUP: assert property (@(posedge ref_clk) disable iff (!rstn) // [R12]
      hashValid && hostMacControl[`PMA_ACCEPT_ALL_BIT] |=> groupAccept)
      else $error("accept all ignored");
   AST_HASH_WR: assert property (@(posedge ref_clk) disable iff (!rstn) // [R10]
      wrAccess && paddr == `PMA_ADDR_HASH_LOW && pstrb == 4'hf && !pslverr
      |=> groupHashLow == $past(pwdata))
      else $error("hash low write lost");
   // index and phy sent to the phy side come from the control fields
   AST_REG_SEL: assert property (@(posedge ref_clk) disable iff (!rstn) // [R2]
      reqValid |-> latReg == phyRegSelect && latPhy == targetPhyNumber)
      else $error("register index mismatch");
endmodule

// ### testbench/pma_host_model.sv
// apb host model standing in for the driver software
`timescale 1ns/10ps
`include "pma_defines.svh"
module pma_host_model (
   input  wire logic        ref_clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // bus idle from time zero
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;

   // one transfer, request held until pready seen high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle count assumed: only the bench watchdog ends this wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // launch a phy access, then poll busy until it clears or 64 more polls pass
   task automatic phy_op(input logic w, input logic [4:0] ph, input logic [4:0] rg,
                         output logic [31:0] c, output logic fb);
      logic e;
      xfer(1'b1, `PMA_ADDR_CONTROL, {16'h0000, ph, rg, 4'h0, w, 1'b1}, c, e);
      xfer(1'b0, `PMA_ADDR_CONTROL, 32'h0000_0000, c, e);
      fb = c[0];
      for (int i = 0; i < 64 && c[0] !== 1'b0; i++)
         xfer(1'b0, `PMA_ADDR_CONTROL, 32'h0000_0000, c, e);
   endtask
endmodule

// ### testbench/phy_mgmt_access_regs_tb.sv
// self-checking bench for the phy management access block
`timescale 1ns/10ps
`include "pma_defines.svh"
module phy_mgmt_access_regs_tb;
   logic        ref_clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        hashValid;
   logic [5:0]  hashIndex;
   logic        groupAccept;
   logic        accessBusy;
   logic [31:0] r;
   logic [31:0] lo;
   logic [31:0] hi;
   logic [15:0] d0;
   logic [15:0] d1;
   logic [4:0]  ph;
   logic [4:0]  rg;
   logic        e;
   logic        fb;
   int          rnd;
   int          n_errors = 0;
   int          checks = 0;

   pma_top DUT (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hashValid(hashValid), .hashIndex(hashIndex),
      .groupAccept(groupAccept), .accessBusy(accessBusy));

   pma_host_model host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // expected filter decision, high word on top
   function automatic logic exp_accept(logic [63:0] tbl, logic [5:0] idx, logic all);
      return all | tbl[idx];
   endfunction

   // verdict and end of run
   task automatic end_of_test;
      if (n_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      end_of_test();
   end

   // main sequence
   initial begin
      rnd = $urandom(32'h982dbcc9);
      rstn = 1'b0;
      hashValid = 1'b0;
      hashIndex = 6'h00;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      host.xfer(1'b0, `PMA_ADDR_HASH_LOW, 32'h0, r, e);
      chk("hash low reset", r, `PMA_HASH_RESET);
      host.xfer(1'b0, `PMA_ADDR_VALUE, 32'h0, r, e);
      chk("value reset", r, 32'h0000_0000);
      host.xfer(1'b0, 12'h0fc, 32'h0, r, e);
      chk("unmapped error", {31'h0, e}, 32'h1);
      // group hash table, with and without accept-all
      lo = $urandom;
      hi = $urandom;
      host.xfer(1'b1, `PMA_ADDR_HASH_LOW, lo, r, e);
      host.xfer(1'b1, `PMA_ADDR_HASH_HIGH, hi, r, e);
      host.xfer(1'b0, `PMA_ADDR_HASH_LOW, 32'h0, r, e);
      chk("hash low", r, lo);
      for (int a = 0; a < 2; a++) begin
         host.xfer(1'b1, `PMA_ADDR_MAC_CTRL, 32'(a) << `PMA_ACCEPT_ALL_BIT, r, e);
         for (int i = 0; i < 64; i++) begin
            hashValid <= 1'b1;
            hashIndex <= 6'(i);
            repeat (2) @(posedge ref_clk);
            chk("accept", 32'(groupAccept), 32'(exp_accept({hi, lo}, 6'(i), a[0])));
         end
         hashValid <= 1'b0;
      end
      // no lookup, no accept even with accept-all still set
      repeat (2) @(posedge ref_clk);
      chk("idle reject", 32'(groupAccept), 32'h0);
      // reserved upper half of the value register
      host.xfer(1'b1, `PMA_ADDR_VALUE, 32'hffff_ffff, r, e);
      host.xfer(1'b0, `PMA_ADDR_VALUE, 32'h0, r, e);
      chk("value upper", r, 32'h0000_ffff);
      // phy writes to two neighbouring registers, then read both back
      for (int k = 0; k < 4; k++) begin
         ph = 5'($urandom);
         rg = 5'($urandom);
         d0 = 16'($urandom);
         d1 = 16'($urandom);
         host.xfer(1'b1, `PMA_ADDR_VALUE, {16'h0000, d0}, r, e);
         host.phy_op(1'b1, ph, rg, r, fb);
         chk("busy held", 32'(fb), 32'h1);
         chk("busy clear", 32'(r[0]), 32'h0);
         host.xfer(1'b1, `PMA_ADDR_VALUE, {16'h0000, d1}, r, e);
         host.phy_op(1'b1, ph, rg ^ 5'h01, r, fb);
         host.xfer(1'b1, `PMA_ADDR_VALUE, 32'h0, r, e);
         host.phy_op(1'b0, ph, rg, r, fb);
         host.xfer(1'b0, `PMA_ADDR_VALUE, 32'h0, r, e);
         chk("read back", r, {16'h0000, d0});
         host.phy_op(1'b0, ph, rg ^ 5'h01, r, fb);
         host.xfer(1'b0, `PMA_ADDR_VALUE, 32'h0, r, e);
         chk("read back next", r, {16'h0000, d1});
         chk("busy pin idle", 32'(accessBusy), 32'h0);
      end
      // corner: busy pin during a hand-launched read, fields read back while busy
      host.xfer(1'b1, `PMA_ADDR_CONTROL, {16'h0000, ph, rg, 4'h0, 2'b01}, r, e);
      repeat (2) @(posedge ref_clk);
      chk("busy pin set", 32'(accessBusy), 32'h1);
      host.xfer(1'b0, `PMA_ADDR_CONTROL, 32'h0, r, e);
      chk("control fields", r, {16'h0000, ph, rg, 4'h0, 2'b01});
      while (r[0] !== 1'b0)
         host.xfer(1'b0, `PMA_ADDR_CONTROL, 32'h0, r, e);
      chk("busy pin clear", 32'(accessBusy), 32'h0);
      host.xfer(1'b0, `PMA_ADDR_VALUE, 32'h0, r, e);
      chk("read again", r, {16'h0000, d0});
      end_of_test();
   end
endmodule
